// file: logic/lhbp_cfg.svh
// Constants of the host bus port: encodings, reset values, timing counts
`ifndef LHBP_CFG_SVH
`define LHBP_CFG_SVH
`define LHBP_ADDR_W 8
`define LHBP_DATA_W 8
`define LHBP_ADDR_RST 8'h00
`define LHBP_CTRL_ADDR 8'h80
`define LHBP_GIE_BIT 0
`define LHBP_CTRL_RST 8'h00
`define LHBP_GIE_RST 1'b0
`define LHBP_SYNC_RST 16'h9C00
`define LHBP_ACC_WAIT 2'h1
`define LHBP_SER_FRAME 16
`define LHBP_STYLE_SEP 1'b0
`define LHBP_STYLE_DS 1'b1
`endif

// file: logic/lhbp_pkg.sv
// Types of the host bus port
package lhbp_pkg;
  typedef enum logic [1:0] {
    LHBP_IDLE = 2'b00,
    LHBP_ACC = 2'b01,
    LHBP_DONE = 2'b10
  } lhbp_state_type;
endpackage

// file: logic/lhbp_cfg_if.sv
// Register-space access between port front ends and the register file
`timescale 1ns/1ns
interface lhbp_cfg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output wr_en, output addr, output wdata, input rdata);
  modport slave (input wr_en, input addr, input wdata, output rdata);
endinterface

// file: logic/lhbp_regmem.sv
// Small configuration memory with registered read data
`timescale 1ns/1ns
`include "lhbp_cfg.svh"
module lhbp_regmem #(
  parameter int DEPTH = 256
) (
  input wire logic clk_i,
  lhbp_cfg_if.slave cfg
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_r;

  // Elaboration refuses a depth that leaves addresses without a word
  if (DEPTH != 256) begin : g_depth_chk
    $error("DEPTH must cover the 8-bit address space");
  end

  // Write port and registered read
  always_ff @(posedge clk_i) begin
    if (cfg.wr_en) begin
      mem[cfg.addr] <= cfg.wdata;
    end
    rdata_r <= mem[cfg.addr];
  end
  assign cfg.rdata = rdata_r;
endmodule

// file: logic/lhbp_serial.sv
// Serial link front end on the host shift clock
`timescale 1ns/1ns
`include "lhbp_cfg.svh"
module lhbp_serial (
  input wire logic sclk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic [7:0] rdata_i,
  output logic sdo_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic rnw_o,
  output logic tgl_o
);
  // Frame: R/W bit, 7 address bits, then 8 data bits, MSB first
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic tgl_r, tgl_nxt;
  logic [7:0] rd_r, rd_nxt;

  // Shift logic; frame restarts whenever chip select is high
  always_comb begin
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tgl_nxt = tgl_r;
    rd_nxt = rd_r;
    if (cs_n_i) begin
      cnt_nxt = 5'h00;
    end else if (cnt_r < 5'h10) begin
      sh_nxt = {sh_r[14:0], sdi_i};
      cnt_nxt = cnt_r + 5'h01;
      if (cnt_r == 5'h07) begin
        rd_nxt = rdata_i;
      end else if (cnt_r > 5'h07) begin
        rd_nxt = {rd_r[6:0], 1'b0};
      end
      if (cnt_r == 5'h0F) begin
        tgl_nxt = ~tgl_r; // Event crosses as a toggle
      end
    end
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      tgl_r <= 1'b0;
      rd_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tgl_r <= tgl_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Words stay stable until the next frame, so the core samples safely
  assign rnw_o = sh_r[15];
  assign addr_o = {1'b0, sh_r[14:8]};
  assign wdata_o = sh_r[7:0];
  assign tgl_o = tgl_r;
  assign sdo_o = rd_r[7];
endmodule

// file: logic/lhbp_top.sv
// Host access port: parallel bus in two styles, serial link, alarm output
`timescale 1ns/1ns
`include "lhbp_cfg.svh"
module lhbp_top
  import lhbp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_clk_i,
  input wire logic pin_control_select_i,
  input wire logic host_type_sel_lo_i,
  input wire logic host_type_sel_hi_i,
  input wire logic serial_port_select_i,
  input wire logic cs_n_i,
  input wire logic wr_rnw_i,
  input wire logic read_or_data_strobe_i,
  input wire logic addr_latch_strobe_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic alarm_i,
  output logic [7:0] data_o,
  output logic [7:0] data_oe_o,
  output logic transfer_done_o,
  output logic irq_n_o,
  output logic irq_oe_o,
  output logic host_mode_o,
  output logic global_irq_enable_o
);
  //----------------------------------------------------------------
  // Input synchronisers
  //----------------------------------------------------------------
  localparam int NS = 16;
  // Idle pin levels: pin control, chip select and strobes high, latch low
  localparam logic [NS-1:0] SYNC_RST = `LHBP_SYNC_RST;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] s3_r;
  assign raw = {pin_control_select_i, host_type_sel_hi_i,
                serial_port_select_i, cs_n_i, wr_rnw_i,
                read_or_data_strobe_i, addr_latch_strobe_i,
                alarm_i, addr_i};

  // Two stages, then a third for edge detection on the clean copy
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic mode_s, style_s, ser_s, cs_s, rw_s, rd_s, ale_s, alarm_s;
  logic [7:0] a_s;
  assign {mode_s, style_s, ser_s, cs_s, rw_s, rd_s, ale_s, alarm_s,
          a_s} = s2_r;
  // Host control only while the mode pin reads low
  logic host_en;
  assign host_en = ~mode_s;
  // Falling edges seen between the second and third stages
  logic ale_fall, rd_fall, wr_fall;
  assign ale_fall = s3_r[9] & ~ale_s;
  assign rd_fall = s3_r[10] & ~rd_s & ~cs_s;
  assign wr_fall = s3_r[11] & ~rw_s & ~cs_s;

  // Data bus gets its own two stages; it is read only once a strobe has
  // crossed, by which time both stages hold the settled word
  logic [7:0] d1_r, d_s;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      d1_r <= 8'h00;
      d_s <= 8'h00;
    end else begin
      d1_r <= data_i;
      d_s <= d1_r;
    end
  end

  // Strobe style decode, shared by start, release and pin logic
  function automatic logic ds_style(input logic sel);
    return sel == `LHBP_STYLE_DS;
  endfunction

  //----------------------------------------------------------------
  // Serial link on the host clock
  //----------------------------------------------------------------
  logic [7:0] ser_addr, ser_wdata, rdata;
  logic ser_rnw, ser_tgl, ser_sdo;
  lhbp_serial u_ser (
    .sclk_i(host_clk_i),
    .rst_i(rst_i),
    .cs_n_i(cs_n_i | ~serial_port_select_i),
    .sdi_i(addr_i[0]),
    .rdata_i(rdata),
    .sdo_o(ser_sdo),
    .addr_o(ser_addr),
    .wdata_o(ser_wdata),
    .rnw_o(ser_rnw),
    .tgl_o(ser_tgl)
  );
  // Frame end crosses as a toggle through two flops; the words it
  // announces stay still until the next frame. A serial read returns
  // the word at the address left by the previous access, since the
  // shift clock outruns a core-side lookup.
  logic [2:0] tg_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tg_r <= 3'h0;
    end else begin
      tg_r <= {tg_r[1:0], ser_tgl};
    end
  end
  // One pulse per received frame
  logic ser_evt;
  assign ser_evt = tg_r[2] ^ tg_r[1];

  //----------------------------------------------------------------
  // Parallel access state machine
  //----------------------------------------------------------------
  // Register space sits behind a small memory with registered reads
  lhbp_cfg_if cfg ();
  lhbp_regmem u_mem (
    .clk_i(clk_i),
    .cfg(cfg)
  );
  assign rdata = cfg.rdata;

  lhbp_state_type st_r, st_nxt;
  logic [7:0] addr_r, addr_nxt, dout_r, dout_nxt, wd_r, wd_nxt;
  logic rd_act_r, rd_act_nxt, done_r, done_nxt, we_r, we_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic gie_r, gie_nxt;
  logic oe_r, oe_nxt, irq_r, irq_nxt;

  // Start of an access in either strobe style
  logic start_rd, start_wr;
  always_comb begin
    if (!ds_style(style_s)) begin
      start_rd = rd_fall;
      start_wr = wr_fall;
    end else begin
      start_rd = rd_fall & rw_s;
      start_wr = rd_fall & ~rw_s;
    end
  end

  // Next-state computation
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    wd_nxt = wd_r;
    rd_act_nxt = rd_act_r;
    done_nxt = done_r;
    we_nxt = 1'b0;
    wait_nxt = wait_r;
    gie_nxt = gie_r;
    if (ale_fall && !ser_s) begin
      addr_nxt = a_s;
    end
    case (st_r)
      LHBP_IDLE: begin
        done_nxt = 1'b0;
        if (host_en && !ser_s && (start_rd || start_wr)) begin
          st_nxt = LHBP_ACC;
          rd_act_nxt = start_rd;
          wd_nxt = d_s;
          wait_nxt = 2'h0;
        end else if (host_en && ser_s && ser_evt) begin
          addr_nxt = ser_addr;
          wd_nxt = ser_wdata;
          we_nxt = ~ser_rnw;
        end
      end
      LHBP_ACC: begin
        wait_nxt = wait_r + 2'h1;
        // Memory read data appears after its own register stage
        if (wait_r == `LHBP_ACC_WAIT) begin
          we_nxt = ~rd_act_r;
          dout_nxt = cfg.rdata;
          st_nxt = LHBP_DONE;
          done_nxt = 1'b1;
        end
      end
      LHBP_DONE: begin
        // Hold completion until the strobe or select is released
        if (cs_s || (rd_s && (ds_style(style_s) || rw_s))) begin
          st_nxt = LHBP_IDLE;
          done_nxt = 1'b0;
          rd_act_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = LHBP_IDLE;
      end
    endcase
    // Enable bit follows any write that lands on the control address
    if (we_nxt && addr_nxt == `LHBP_CTRL_ADDR) begin
      gie_nxt = wd_nxt[`LHBP_GIE_BIT];
    end
  end

  // Output preparation; in parallel mode the data bus is driven only for a selected read
  always_comb begin
    oe_nxt = host_en && !ser_s && !cs_s && rd_act_nxt;
    irq_nxt = host_en && gie_nxt && alarm_s;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= LHBP_IDLE;
      addr_r <= `LHBP_ADDR_RST;
      dout_r <= 8'h00;
      wd_r <= 8'h00;
      rd_act_r <= 1'b0;
      done_r <= 1'b0;
      we_r <= 1'b0;
      wait_r <= 2'h0;
      gie_r <= `LHBP_GIE_RST;
      oe_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      wd_r <= wd_nxt;
      rd_act_r <= rd_act_nxt;
      done_r <= done_nxt;
      we_r <= we_nxt;
      wait_r <= wait_nxt;
      gie_r <= gie_nxt;
      oe_r <= oe_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Memory port driven from registers only
  assign cfg.wr_en = we_r;
  assign cfg.addr = addr_r;
  assign cfg.wdata = wd_r;

  //----------------------------------------------------------------
  // Registered pin drivers
  //----------------------------------------------------------------
  logic [7:0] dpin_r, dpin_nxt, doe_r, doe_nxt;
  logic done_pin_r, done_pin_nxt, hm_r, hm_nxt;
  logic sdo_r, sdo_nxt;

  // Pin values for the next edge
  always_comb begin
    // First stage for the serial bit; the pin register is the second
    sdo_nxt = ser_sdo;
    // Serial output replaces data bit 0 in serial mode
    dpin_nxt = ser_s ? {7'h00, sdo_r} : dout_r;
    doe_nxt = ser_s ? {7'h00, host_en & ~cs_s} : {8{oe_r}};
    // Ready is active high, acknowledge active low
    done_pin_nxt = ds_style(style_s) ? ~done_r : done_r;
    hm_nxt = host_en;
  end

  // Pin registers; reset parks the bus released and the handshake pin high, its idle level in the data strobe style
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dpin_r <= 8'h00;
      doe_r <= 8'h00;
      done_pin_r <= 1'b1;
      hm_r <= 1'b0;
      sdo_r <= 1'b0;
    end else begin
      dpin_r <= dpin_nxt;
      doe_r <= doe_nxt;
      done_pin_r <= done_pin_nxt;
      hm_r <= hm_nxt;
      sdo_r <= sdo_nxt;
    end
  end

  assign data_o = dpin_r;
  assign data_oe_o = doe_r;
  assign transfer_done_o = done_pin_r;
  assign irq_n_o = 1'b0;
  assign irq_oe_o = irq_r;
  assign host_mode_o = hm_r;
  assign global_irq_enable_o = gie_r;
endmodule

// file: verif/lhbp_top_properties.sv
// Pin-level checks of the host bus port
`timescale 1ns/1ns
module lhbp_top_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_control_select_i,
  input wire logic host_type_sel_hi_i,
  input wire logic serial_port_select_i,
  input wire logic cs_n_i,
  input wire logic wr_rnw_i,
  input wire logic read_or_data_strobe_i,
  input wire logic alarm_i,
  input wire logic [7:0] data_oe_o,
  input wire logic transfer_done_o,
  input wire logic irq_oe_o,
  input wire logic host_mode_o,
  input wire logic global_irq_enable_o
);
  // Selected parallel cycle in host mode; strobes count only then
  logic par_w;
  assign par_w = !cs_n_i && host_mode_o && !serial_port_select_i;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Long windows cover the two sync flops plus the access itself
  property p_mode;
    pin_control_select_i [*6] |-> !host_mode_o;
  endproperty
  a_mode: assert property (p_mode)
    else $error("host mode with pin high");
  property p_idle;
    (cs_n_i && $stable(host_type_sel_hi_i)) [*8] |->
      data_oe_o == 8'h00 && transfer_done_o == host_type_sel_hi_i;
  endproperty
  a_idle: assert property (p_idle)
    else $error("port busy while deselected");
  property p_swr;
    (par_w && !host_type_sel_hi_i && !wr_rnw_i) [*8] |-> transfer_done_o;
  endproperty
  a_swr: assert property (p_swr)
    else $error("no ready after write strobe");
  property p_srd;
    (par_w && !host_type_sel_hi_i && !read_or_data_strobe_i) [*8]
      |-> transfer_done_o;
  endproperty
  a_srd: assert property (p_srd)
    else $error("no ready after read strobe");
  property p_ds;
    (par_w && host_type_sel_hi_i && !read_or_data_strobe_i) [*8]
      |-> !transfer_done_o;
  endproperty
  a_ds: assert property (p_ds)
    else $error("no acknowledge after data strobe");
  property p_oe;
    (par_w && wr_rnw_i && !read_or_data_strobe_i) [*8]
      |-> data_oe_o == 8'hFF;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data bus not driven in read");
  property p_gie;
    !global_irq_enable_o [*3] |-> !irq_oe_o;
  endproperty
  a_gie: assert property (p_gie)
    else $error("interrupt while disabled");
  property p_irq;
    (global_irq_enable_o && alarm_i) [*4] |-> irq_oe_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("alarm not signalled");
endmodule
bind lhbp_top lhbp_top_properties i_lhbp_top_properties (.clk_i, .rst_i,
  .pin_control_select_i, .host_type_sel_hi_i, .serial_port_select_i,
  .cs_n_i, .wr_rnw_i, .read_or_data_strobe_i, .alarm_i, .data_oe_o,
  .transfer_done_o, .irq_oe_o, .host_mode_o, .global_irq_enable_o);

// file: verif/lhbp_host_model.sv
// Host processor model for the parallel bus and serial link
`timescale 1ns/1ns
module lhbp_host_model (
  input wire logic clk_i,
  input wire logic style_i,
  input wire logic done_i,
  input wire logic [7:0] bus_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic wr_rnw_o,
  output logic stb_n_o,
  output logic ale_o,
  output logic [7:0] addr_o,
  output logic [7:0] dat_o
);
  // Parked bus: deselected, strobes high, shift clock still
  initial begin
    // Parallel accesses run unclocked, far below the host clock limit
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    wr_rnw_o = 1'b1;
    stb_n_o = 1'b1;
    ale_o = 1'b0;
    addr_o = 8'h00;
    dat_o = 8'hFF;
  end
  // One parallel access; ok says whether the port answered in time
  task automatic acc(input logic rd, input logic [7:0] a, d,
    output logic [7:0] q, output logic ok);
    ok = 1'b0;
    q = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    addr_o = a;
    ale_o = 1'b1;
    repeat (2) @(negedge clk_i);
    ale_o = 1'b0;
    dat_o = rd ? ~d : d;
    @(negedge clk_i);
    if (style_i) begin
      wr_rnw_o = rd;
      stb_n_o = 1'b0;
    end else if (rd) begin
      stb_n_o = 1'b0;
    end else begin
      wr_rnw_o = 1'b0;
    end
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_i);
      ok = done_i === !style_i;
      q = bus_i;
    end
    // Extra hold lets the checker see a long strobe
    repeat (4) @(negedge clk_i);
    stb_n_o = 1'b1;
    wr_rnw_o = 1'b1;
    cs_n_o = 1'b1;
    addr_o = ~a;
    dat_o = ~d;
    repeat (6) @(negedge clk_i);
  endtask
  // Serial frame, first bit first; clock runs only inside the frame
  task automatic ser(input logic [15:0] f);
    cs_n_o = 1'b0;
    #12;
    for (int i = 15; i >= 0; i--) begin
      addr_o[0] = f[i];
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    #12 cs_n_o = 1'b1;
  endtask
endmodule

// file: verif/lhbp_top_bench.sv
// Self-checking bench of the host bus port
`timescale 1ns/1ns
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module lhbp_top_bench;
  logic clk_i, rst_i, pin_i, lo_i, style_i, ser_i, alarm_i;
  logic hclk, cs_n, wr_rnw, stb_n, ale, done, irq_n, irq_oe, mode, global_irq_enable;
  logic [7:0] addr, hdat, ddat, oe;
  wire [7:0] bus = (ddat & oe) | (hdat & ~oe);
  int err_count = 0;
  int total_checks = 0;
  lhbp_top i_lhbp_top (.clk_i, .rst_i, .host_clk_i(hclk),
    .pin_control_select_i(pin_i), .host_type_sel_lo_i(lo_i),
    .host_type_sel_hi_i(style_i), .serial_port_select_i(ser_i),
    .cs_n_i(cs_n), .wr_rnw_i(wr_rnw), .read_or_data_strobe_i(stb_n),
    .addr_latch_strobe_i(ale), .addr_i(addr), .data_i(bus), .alarm_i,
    .data_o(ddat), .data_oe_o(oe), .transfer_done_o(done),
    .irq_n_o(irq_n), .irq_oe_o(irq_oe), .host_mode_o(mode),
    .global_irq_enable_o(global_irq_enable));
  lhbp_host_model i_lhbp_host_model (.clk_i, .style_i, .done_i(done),
    .bus_i(bus), .sclk_o(hclk), .cs_n_o(cs_n), .wr_rnw_o(wr_rnw),
    .stb_n_o(stb_n), .ale_o(ale), .addr_o(addr), .dat_o(hdat));
  // Core clock, 40 ns period
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Access through the host model; an answer other than the expected one ends the run
  task automatic xfer(input logic rd, input logic [7:0] a, d,
    input logic ok_exp);
    logic [7:0] q;
    logic ok;
    i_lhbp_host_model.acc(rd, a, d, q, ok);
    `CHK("answer", ok_exp, ok)
    if (rd && ok_exp) `CHK("rdata", d, q)
    if (ok !== ok_exp) wrap_up();
  endtask
  task automatic t_sep();
    {style_i, lo_i} = 2'h0;
    xfer(1'b0, 8'h12, 8'h3C, 1'b1);
    xfer(1'b0, 8'h13, 8'hA5, 1'b1);
    xfer(1'b1, 8'h12, 8'h3C, 1'b1);
    xfer(1'b1, 8'h13, 8'hA5, 1'b1);
  endtask
  task automatic t_ds();
    {style_i, lo_i} = 2'h3;
    xfer(1'b0, 8'hFF, 8'h81, 1'b1);
    xfer(1'b0, 8'h00, 8'h7E, 1'b1);
    xfer(1'b1, 8'hFF, 8'h81, 1'b1);
    xfer(1'b1, 8'h00, 8'h7E, 1'b1);
  endtask
  // Serial write crosses domains, then read back on the parallel bus
  task automatic t_ser();
    ser_i = 1'b1;
    i_lhbp_host_model.ser({1'b0, 7'h21, 8'h5A});
    repeat (10) @(negedge clk_i);
    ser_i = 1'b0;
    repeat (4) @(negedge clk_i);
    xfer(1'b1, 8'h21, 8'h5A, 1'b1);
  endtask
  task automatic t_irq();
    {style_i, lo_i} = 2'h2;
    alarm_i = 1'b1;
    repeat (6) @(negedge clk_i);
    `CHK("irq_oe", 1'b0, irq_oe)
    xfer(1'b0, 8'h80, 8'h01, 1'b1);
    `CHK("gie", 1'b1, global_irq_enable)
    `CHK("irq_oe", 1'b1, irq_oe)
    `CHK("irq_n", 1'b0, irq_n)
    alarm_i = 1'b0;
    repeat (6) @(negedge clk_i);
    `CHK("irq_oe", 1'b0, irq_oe)
    alarm_i = 1'b1;
    xfer(1'b0, 8'h80, 8'h00, 1'b1);
    `CHK("irq_oe", 1'b0, irq_oe)
  endtask
  // Pin control refuses bus access until the pin goes low again
  task automatic t_mode();
    {style_i, lo_i} = 2'h1;
    pin_i = 1'b1;
    repeat (8) @(negedge clk_i);
    `CHK("mode", 1'b0, mode)
    xfer(1'b1, 8'h12, 8'h3C, 1'b0);
    pin_i = 1'b0;
    repeat (8) @(negedge clk_i);
    `CHK("mode", 1'b1, mode)
    xfer(1'b1, 8'h12, 8'h3C, 1'b1);
  endtask
  // Reset in mid-run parks the port and clears the interrupt enable
  task automatic t_rst();
    xfer(1'b0, 8'h80, 8'h01, 1'b1);
    @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    `CHK("rst_gie", 1'b0, global_irq_enable)
    `CHK("rst_irq_oe", 1'b0, irq_oe)
    `CHK("rst_oe", 8'h00, oe)
    `CHK("rst_done", 1'b1, done)
    `CHK("rst_mode", 1'b0, mode)
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    `CHK("gie_after", 1'b0, global_irq_enable)
    `CHK("irq_after", 1'b0, irq_oe)
    `CHK("mode_after", 1'b1, mode)
    xfer(1'b1, 8'h12, 8'h3C, 1'b1);
  endtask
  initial begin
    {rst_i, pin_i, lo_i, style_i, ser_i, alarm_i} = 6'h20;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    t_sep();
    t_ds();
    t_ser();
    t_irq();
    t_rst();
    t_mode();
    wrap_up();
  end
  // Hang guard
  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end
endmodule
